/* File: rtl/dcr_pkg.sv */
// shared constants for the chained converter serial link
package dcr_pkg;
  localparam int          FRAME_BITS    = 24;
  localparam int          CMD_MSB       = 23;
  localparam int          CMD_LSB       = 20;
  localparam int          ADDR_MSB      = 19;
  localparam int          ADDR_LSB      = 16;
  localparam int          DATA_MSB      = 15;
  localparam int          NUM_CH        = 8;
  localparam int          PD_W          = 2;
  localparam logic [3:0]  CMD_NOP       = 4'h0;
  localparam logic [3:0]  CMD_WR_IN     = 4'h1;
  localparam logic [3:0]  CMD_UPD_DAC   = 4'h2;
  localparam logic [3:0]  CMD_WR_UPD    = 4'h3;
  localparam logic [3:0]  CMD_PWR       = 4'h4;
  localparam logic [3:0]  CMD_CHAIN     = 4'h8;
  localparam logic [3:0]  CMD_READBACK  = 4'h9;
  localparam logic [3:0]  CMD_NOP_CHAIN = 4'hf;
  localparam logic [1:0]  PD_NORMAL     = 2'h0;
  localparam logic [1:0]  PD_GND_1K     = 2'h1;
  localparam logic [1:0]  PD_TRISTATE   = 2'h3;
  localparam logic        CHAIN_RST     = 1'b0;
  localparam logic [15:0] PD_RST        = 16'h0000;
  // host register offsets, apb byte addresses
  localparam logic [7:0]  REG_TXD       = 8'h00;
  localparam logic [7:0]  REG_CTRL      = 8'h04;
  localparam logic [7:0]  REG_STAT      = 8'h08;
  localparam logic [7:0]  REG_RXD       = 8'h0c;
  localparam logic [7:0]  REG_DIV       = 8'h10;
  localparam logic [15:0] DIV_RST       = 16'h0004;
  localparam logic [7:0]  WORDS_RST     = 8'h01;
endpackage

/* File: rtl/dcr_link_if.sv */
// serial link between host controller and converter
`timescale 1ns/100ps
interface dcr_link_if;
  logic frame_n;
  logic sclk;
  logic serial_data_input;
  logic chain_data_output;
  logic chain_data_oe_n;
  modport host (output frame_n, output sclk, output serial_data_input,
                input chain_data_output);
  modport dev  (input frame_n, input sclk, input serial_data_input,
                output chain_data_output, output chain_data_oe_n);
endinterface

/* File: rtl/dcr_device.sv */
// converter serial command end: chain, readback, power-down
// What this block does
// - frame is 24 bits msb first: cmd, addr, data
// - sample data in on falling clock, frame low
// - command 1000 sets chain mode from bit0
// - reset leaves standalone mode, chain bit zero
// - extra bits ripple out on chain output
// - output changes rising, partner samples falling
// - host gives 24 times N clocks per frame
// - odd clock count still executes held bits
// - frame rise latches, executes, stops shifting
// - gated clock: exact burst, then frame rises
// - command 1001 selects input register for readback
// - readback enables output even when disabled
// - next frame shifts out selected register
// - host collects readback with no-op frame
// - readback: four zero bits, then 16 data
// - frame high: output holds last bit weakly
// - command 0100 loads eight 2-bit power fields
// - field 00 normal, 01 ground 1k, 11 tristate
// - power-down keeps output registers, still updatable
// - input and output registers, load strobe transfers
// - clock reaches shifter whole time frame is low
`timescale 1ns/100ps
module dcr_device #(
  parameter int NCH = dcr_pkg::NUM_CH
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  dcr_link_if.dev               link,
  input  wire logic             load_strobe_n,
  output logic                  chain_enable_bit,
  output logic [NCH*2-1:0]      pd_mode,
  output logic [NCH-1:0]        ch_gnd_1k,
  output logic [NCH-1:0]        ch_tristate,
  output logic [NCH*16-1:0]     in_regs,
  output logic [NCH*16-1:0]     out_regs
);
  // ****************************************************
  // pin synchronisers and edge detection
  // ****************************************************
  // every pin passes two flops, so the link half period must stay
  // well above three pclk or link edges are lost
  logic [1:0] fr_s_r, ck_s_r, di_s_r;
  logic [1:0] fr_s_nxt, ck_s_nxt, di_s_nxt;
  logic       fr_d_r, ck_d_r, ld_d_r;
  logic [1:0] ld_s_r, ld_s_nxt;
  logic       fr_d_nxt, ck_d_nxt, ld_d_nxt;
  logic       fr, ck, di, ld;
  logic       ck_fall, ck_rise, fr_rise, ld_fall;

  always_comb begin
    fr_s_nxt = {fr_s_r[0], link.frame_n};
    ck_s_nxt = {ck_s_r[0], link.sclk};
    di_s_nxt = {di_s_r[0], link.serial_data_input};
    ld_s_nxt = {ld_s_r[0], load_strobe_n};
    fr_d_nxt = fr_s_r[1];
    ck_d_nxt = ck_s_r[1];
    ld_d_nxt = ld_s_r[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fr_s_r <= 2'h3;
      ck_s_r <= 2'h0;
      di_s_r <= 2'h0;
      ld_s_r <= 2'h3;
      fr_d_r <= 1'b1;
      ck_d_r <= 1'b0;
      ld_d_r <= 1'b1;
    end else begin
      fr_s_r <= fr_s_nxt;
      ck_s_r <= ck_s_nxt;
      di_s_r <= di_s_nxt;
      ld_s_r <= ld_s_nxt;
      fr_d_r <= fr_d_nxt;
      ck_d_r <= ck_d_nxt;
      ld_d_r <= ld_d_nxt;
    end
  end

  assign fr      = fr_s_r[1];
  assign ck      = ck_s_r[1];
  assign di      = di_s_r[1];
  assign ld      = ld_s_r[1];
  // the shifter follows every clock edge while the frame is low
  assign ck_fall = ck_d_r & ~ck & ~fr;
  assign ck_rise = ~ck_d_r & ck & ~fr;
  assign fr_rise = ~fr_d_r & fr;
  assign ld_fall = ld_d_r & ~ld;

  // ****************************************************
  // shift path, command execution, register banks
  // ****************************************************
  logic [23:0]         sh_r, sh_nxt;
  logic                so_r, so_nxt;
  logic                chain_r, chain_nxt;
  logic                rd_pend_r, rd_pend_nxt;
  logic                rd_act_r, rd_act_nxt;
  logic [15:0]         pd_r, pd_nxt;
  logic [NCH*16-1:0]   in_r, in_nxt;
  logic [NCH*16-1:0]   out_r, out_nxt;
  logic [3:0]          cmd, adr;
  logic [15:0]         dat;
  logic [2:0]          ch;

  assign cmd = sh_r[dcr_pkg::CMD_MSB:dcr_pkg::CMD_LSB];
  assign adr = sh_r[dcr_pkg::ADDR_MSB:dcr_pkg::ADDR_LSB];
  assign dat = sh_r[dcr_pkg::DATA_MSB:0];
  assign ch  = adr[2:0];
  // sh_r is not cleared between frames, so in a long frame the
  // previous word leads the rippled bits out

  always_comb begin
    sh_nxt      = sh_r;
    so_nxt      = so_r;
    chain_nxt   = chain_r;
    rd_pend_nxt = rd_pend_r;
    rd_act_nxt  = rd_act_r;
    pd_nxt      = pd_r;
    in_nxt      = in_r;
    out_nxt     = out_r;
    // msb leaves on rising edge, new bit enters on falling
    if (ck_rise)
      so_nxt = sh_r[dcr_pkg::FRAME_BITS-1];
    if (ck_fall)
      sh_nxt = {sh_r[dcr_pkg::FRAME_BITS-2:0], di};
    // a short frame is still executed as held
    if (fr_rise) begin
      rd_act_nxt = 1'b0;
      case (cmd)
        dcr_pkg::CMD_CHAIN: chain_nxt = dat[0];
        dcr_pkg::CMD_PWR:   pd_nxt    = dat;
        dcr_pkg::CMD_WR_IN:
          in_nxt[ch*16 +: 16] = dat;
        dcr_pkg::CMD_WR_UPD: begin
          in_nxt[ch*16 +: 16]  = dat;
          out_nxt[ch*16 +: 16] = dat;
        end
        dcr_pkg::CMD_UPD_DAC:
          for (int i = 0; i < NCH; i++)
            if (dat[i])
              out_nxt[i*16 +: 16] = in_r[i*16 +: 16];
        dcr_pkg::CMD_READBACK: begin
          // readback word sits at positions 19..4
          rd_pend_nxt = 1'b1;
          sh_nxt = {4'h0, in_r[ch*16 +: 16], 4'h0};
        end
        default: ;
      endcase
      if (cmd != dcr_pkg::CMD_READBACK && rd_pend_r) begin
        rd_pend_nxt = 1'b0;
      end
    end
    // next frame drives the held readback word out
    if (~fr && fr_d_r && rd_pend_r) begin
      rd_act_nxt  = 1'b1;
      rd_pend_nxt = 1'b0;
    end
    // load strobe moves input to output registers
    if (ld_fall)
      out_nxt = in_nxt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_r      <= 24'h000000;
      so_r      <= 1'b0;
      chain_r   <= dcr_pkg::CHAIN_RST;
      rd_pend_r <= 1'b0;
      rd_act_r  <= 1'b0;
      pd_r      <= dcr_pkg::PD_RST;
      in_r      <= '0;
      out_r     <= '0;
    end else begin
      sh_r      <= sh_nxt;
      so_r      <= so_nxt;
      chain_r   <= chain_nxt;
      rd_pend_r <= rd_pend_nxt;
      rd_act_r  <= rd_act_nxt;
      pd_r      <= pd_nxt;
      in_r      <= in_nxt;
      out_r     <= out_nxt;
    end
  end

  // ****************************************************
  // outputs and power-down decode
  // ****************************************************
  // so_r keeps its last bit between frames: the weak hold
  assign link.chain_data_output = so_r;
  // the driver lets go while the frame is high, so a neighbour on a
  // shared line can overdrive the held level
  assign link.chain_data_oe_n   = ~((chain_r | rd_act_r) & ~fr);
  assign chain_enable_bit       = chain_r;
  assign pd_mode                = pd_r;
  assign in_regs                = in_r;
  assign out_regs               = out_r;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_pd
      // 10 is not decoded: treated as normal operation
      assign ch_gnd_1k[g]   = pd_r[g*2 +: 2] == dcr_pkg::PD_GND_1K;
      assign ch_tristate[g] = pd_r[g*2 +: 2] == dcr_pkg::PD_TRISTATE;
    end
  endgenerate
endmodule

/* File: rtl/dcr_host.sv */
// host serial controller: apb registers drive link frames
`timescale 1ns/100ps
module dcr_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  dcr_link_if.host         link
);
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_LOW  = 3'b010,
    HS_HIGH = 3'b100
  } dcr_hst_e;

  // ****************************************************
  // registers and serial engine
  // ****************************************************
  dcr_hst_e    st_r, st_nxt;
  logic [23:0] tx_r, tx_nxt;
  logic [23:0] rx_r, rx_nxt;
  logic [15:0] div_r, div_nxt, cnt_r, cnt_nxt;
  logic [7:0]  words_r, words_nxt;
  logic [12:0] bits_r, bits_nxt;
  logic        fr_r, fr_nxt, ck_r, ck_nxt, do_r, do_nxt;
  logic        rx_tk_r, rx_tk_nxt;
  logic [1:0]  si_s_r;
  logic        busy, wr, rd, tick;

  assign wr   = psel & penable & pwrite;
  assign rd   = psel & ~pwrite;
  assign busy = st_r != HS_IDLE;
  assign tick = cnt_r == div_r;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    st_nxt = st_r; tx_nxt = tx_r; rx_nxt = rx_r; div_nxt = div_r;
    words_nxt = words_r; bits_nxt = bits_r; fr_nxt = fr_r;
    ck_nxt = ck_r; do_nxt = do_r;
    rx_tk_nxt = 1'b0;
    // the device answer crosses two syncs: take it a cycle after the fall
    if (rx_tk_r)
      rx_nxt = {rx_r[22:0], si_s_r[1]};
    cnt_nxt = tick ? 16'h0000 : cnt_r + 16'h0001;
    if (wr && paddr == dcr_pkg::REG_DIV && !busy)
      div_nxt = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
    if (wr && paddr == dcr_pkg::REG_CTRL && !busy)
      words_nxt = (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
    unique case (st_r)
      HS_IDLE:
        if (wr && paddr == dcr_pkg::REG_TXD) begin
          tx_nxt   = pwdata[23:0];
          // full 24 bits per chained device
          bits_nxt = 13'(words_r) * 13'd24;
          fr_nxt   = 1'b0;
          do_nxt   = pwdata[23];
          cnt_nxt  = 16'h0000;
          st_nxt   = HS_LOW;
        end
      HS_LOW:
        if (tick && bits_r == 13'd0) begin
          // frame rises half a period after the final fall
          fr_nxt = 1'b1;
          st_nxt = HS_IDLE;
        end else if (tick) begin
          // data moves with the rising edge, stable at the fall
          ck_nxt = 1'b1;
          do_nxt = tx_r[23];
          st_nxt = HS_HIGH;
        end
      HS_HIGH:
        if (tick) begin
          // falling edge: device output is taken one cycle later
          ck_nxt    = 1'b0;
          rx_tk_nxt = 1'b1;
          tx_nxt    = {tx_r[22:0], 1'b0};
          bits_nxt  = bits_r - 13'd1;
          st_nxt    = HS_LOW;
        end
      default: st_nxt = HS_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r    <= HS_IDLE;
      tx_r    <= 24'h000000;
      rx_r    <= 24'h000000;
      div_r   <= dcr_pkg::DIV_RST;
      cnt_r   <= 16'h0000;
      words_r <= dcr_pkg::WORDS_RST;
      bits_r  <= 13'h0000;
      fr_r    <= 1'b1;
      ck_r    <= 1'b0;
      do_r    <= 1'b0;
      rx_tk_r <= 1'b0;
      si_s_r  <= 2'h0;
    end else begin
      st_r    <= st_nxt;
      tx_r    <= tx_nxt;
      rx_r    <= rx_nxt;
      div_r   <= div_nxt;
      cnt_r   <= cnt_nxt;
      words_r <= words_nxt;
      bits_r  <= bits_nxt;
      fr_r    <= fr_nxt;
      ck_r    <= ck_nxt;
      do_r    <= do_nxt;
      rx_tk_r <= rx_tk_nxt;
      si_s_r  <= {si_s_r[0], link.chain_data_output};
    end
  end

  // ****************************************************
  // read mux and pins
  // ****************************************************
  always_comb begin
    prdata = 32'h00000000;
    if (rd) begin
      case (paddr)
        dcr_pkg::REG_TXD:  prdata = {8'h00, tx_r};
        dcr_pkg::REG_CTRL: prdata = {24'h000000, words_r};
        dcr_pkg::REG_STAT: prdata = {31'h00000000, busy};
        dcr_pkg::REG_RXD:  prdata = {8'h00, rx_r};
        dcr_pkg::REG_DIV:  prdata = {16'h0000, div_r};
        default:           prdata = 32'h00000000;
      endcase
    end
  end

  assign link.frame_n           = fr_r;
  assign link.sclk              = ck_r;
  assign link.serial_data_input = do_r;
endmodule

/* File: testbench/dcr_link_chk.sv */
// protocol checker for the converter serial link
`timescale 1ns/100ps
module dcr_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_n,
  input wire logic sclk,
  input wire logic serial_data_input,
  input wire logic chain_data_output,
  input wire logic chain_data_oe_n
);
  // ****
  // clock rises counted per frame
  // ****
  logic [7:0] rises_r;
  logic [7:0] rises_nxt;
  logic       sclk_r;
  always_comb begin
    rises_nxt = frame_n ? 8'h00 : rises_r;
    if (!frame_n && sclk && !sclk_r) begin
      rises_nxt = rises_r + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rises_r <= 8'h00;
      sclk_r  <= 1'b0;
    end else begin
      rises_r <= rises_nxt;
      sclk_r  <= sclk;
    end
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_sdi_stable_fall: assert property (
    $fell(sclk) |-> $stable(serial_data_input))
    else $error("sdi moved at sclk fall");
  a_half_period: assert property (
    $rose(sclk) |=> sclk [*4]) else $error("sclk high too short");
  a_out_on_rise: assert property (
    !frame_n && $changed(chain_data_output) |-> sclk)
    else $error("output moved while sclk low");
  a_hold_idle: assert property (
    frame_n && $past(frame_n, 4) |-> $stable(chain_data_output))
    else $error("idle output changed");
  a_weak_idle: assert property (
    frame_n && $past(frame_n, 4) |-> chain_data_oe_n)
    else $error("output driven while idle");
  a_gated_clock: assert property (
    frame_n && $past(frame_n) |-> !sclk) else $error("sclk outside frame");
  a_whole_words: assert property (
    $rose(frame_n) |-> rises_r != 8'h00 && rises_r % 8'h18 == 8'h00)
    else $error("frame not whole words");
  a_burst_starts: assert property (
    $fell(frame_n) |-> ##[1:40] sclk) else $error("no clock in frame");
  c_two_words: cover property ($rose(frame_n) && rises_r == 8'h30);
  c_one_word: cover property ($rose(frame_n) && rises_r == 8'h18);
  c_drive: cover property ($fell(chain_data_oe_n));
endmodule

/* File: testbench/tb.sv */
// self-checking bench: apb host driving the converter end
`timescale 1ns/100ps
module tb;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         load_strobe_n;
  logic         chain_enable_bit;
  logic [15:0]  pd_mode;
  logic [7:0]   ch_gnd_1k;
  logic [7:0]   ch_tristate;
  logic [127:0] in_regs;
  logic [127:0] out_regs;
  logic [31:0]  q;
  int           mismatches;
  int           checked;
  dcr_link_if lnk ();
  dcr_host i_dcr_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(lnk));
  dcr_device i_dcr_device (.pclk(pclk), .presetn(presetn), .link(lnk),
    .load_strobe_n(load_strobe_n), .chain_enable_bit(chain_enable_bit),
    .pd_mode(pd_mode), .ch_gnd_1k(ch_gnd_1k), .ch_tristate(ch_tristate),
    .in_regs(in_regs), .out_regs(out_regs));
  dcr_link_chk i_dcr_link_chk (.pclk(pclk), .presetn(presetn),
    .frame_n(lnk.frame_n), .sclk(lnk.sclk),
    .serial_data_input(lnk.serial_data_input),
    .chain_data_output(lnk.chain_data_output),
    .chain_data_oe_n(lnk.chain_data_oe_n));
  // ****
  // tasks
  // ****
  task automatic summarize();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [127:0] seen, input logic [127:0] exp,
                     input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask
  // waits for the frame to finish, then lets the device execute it
  task automatic send(input logic [23:0] w);
    int n;
    n = 0;
    apb(1'b1, dcr_pkg::REG_TXD, {8'h00, w});
    do begin
      apb(1'b0, dcr_pkg::REG_STAT, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 500);
    if (q[0] !== 1'b0) begin
      mismatches++;
      summarize();
    end
    repeat (5) @(posedge pclk);
  endtask
  // ****
  // clock and scenarios
  // ****
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; load_strobe_n = 1'b1;
    mismatches = 0; checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk(chain_enable_bit, dcr_pkg::CHAIN_RST, "chain reset");
    apb(1'b0, 8'h20, 32'h0);
    chk({pslverr, q}, 33'h0, "unmapped read");
    send(24'h15a5c3);
    chk(in_regs[80+:16], 16'ha5c3, "input write");
    load_strobe_n <= 1'b0;
    repeat (5) @(posedge pclk);
    load_strobe_n <= 1'b1;
    chk(out_regs[80+:16], 16'ha5c3, "strobe transfer");
    apb(1'b1, dcr_pkg::REG_CTRL, 32'h2);
    send(24'h153c3c);
    chk(in_regs[80+:16], 16'ha5c3, "word rippled out");
    apb(1'b0, dcr_pkg::REG_RXD, 32'h0);
    chk(q[23:0], 24'h153c3c, "ripple data");
    apb(1'b1, dcr_pkg::REG_CTRL, 32'h1);
    send(24'h40c0b4);
    chk(pd_mode, 16'hc0b4, "power fields");
    chk({ch_gnd_1k, ch_tristate}, 16'h0284, "power decode");
    send(24'h321234);
    chk(out_regs[32+:16], 16'h1234, "update while down");
    chk(pd_mode, 16'hc0b4, "fields kept");
    send(24'h11beef);
    send(24'h91ffff);
    send(24'h000000);
    apb(1'b0, dcr_pkg::REG_RXD, 32'h0);
    chk(q[19:4], 16'hbeef, "readback standalone");
    send(24'h200002);
    chk(out_regs[16+:16], 16'hbeef, "update from input");
    send(24'h800001);
    chk(chain_enable_bit, 1'b1, "chain on");
    send(24'h950000);
    send(24'hf00000);
    apb(1'b0, dcr_pkg::REG_RXD, 32'h0);
    chk(q[19:4], 16'ha5c3, "readback chained");
    send(24'h800000);
    chk(chain_enable_bit, 1'b0, "chain off");
    send(24'h800001);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(chain_enable_bit, dcr_pkg::CHAIN_RST, "chain after reset");
    summarize();
  end
endmodule
